// file: rtl/timer_pkg.sv
// Constants and types shared by the cascadable timer and its counter units
package timer_pkg;

  // --------------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_LO = 8'h00;
  localparam logic [7:0] OFS_CTRL_HI = 8'h04;
  localparam logic [7:0] OFS_PERIOD_LO = 8'h08;
  localparam logic [7:0] OFS_PERIOD_HI = 8'h0C;
  localparam logic [7:0] OFS_DUTY_LO = 8'h10;
  localparam logic [7:0] OFS_DUTY_HI = 8'h14;
  localparam logic [7:0] OFS_COUNT_LO = 8'h18;
  localparam logic [7:0] OFS_COUNT_HI = 8'h1C;
  localparam logic [7:0] OFS_CONFIG = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // --------------------------------------------------------------------
  // Control and config register fields
  // --------------------------------------------------------------------
  localparam int CTRL_FF_BIT = 7;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CFG_SRC_BIT = 0;

  // --------------------------------------------------------------------
  // Reset values and widths
  // --------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam int PRESCALE_W = 11;
  localparam int LOWFREQ_DIV_W = 3;
  localparam int SYNC_STAGES = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // --------------------------------------------------------------------
  // Modes and source clocks
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_TIMER8 = 3'b000,
    MODE_PDO8 = 3'b001,
    MODE_PWM8 = 3'b010,
    MODE_LOWER16 = 3'b011,
    MODE_TIMER16 = 3'b100,
    MODE_RSVD5 = 3'b101,
    MODE_RSVD6 = 3'b110,
    MODE_RSVD7 = 3'b111
  } mode_t;

  typedef enum logic [2:0] {
    SRC_DIV11 = 3'b000,
    SRC_DIV7 = 3'b001,
    SRC_DIV5 = 3'b010,
    SRC_DIV3 = 3'b011,
    SRC_LOWFREQ = 3'b100,
    SRC_DIV1 = 3'b101,
    SRC_DIV0 = 3'b110,
    SRC_EXT = 3'b111
  } src_t;

endpackage

// file: rtl/counter_if.sv
// Signals between the timer top and one 8-bit counter unit
`timescale 1ns/1ps
interface counter_if;
  logic inc;
  logic run;
  logic pwm_mode;
  logic clr;
  logic duty_wr;
  logic ff_wr;
  logic ff_val;
  logic [7:0] wdata;
  logic [7:0] count;
  logic [7:0] duty_rd;
  logic carry;
  logic ff;
  logic irq;

  modport ctl (
    output inc, run, pwm_mode, clr, duty_wr, ff_wr, ff_val, wdata,
    input count, duty_rd, carry, ff, irq
  );
  modport unit (
    input inc, run, pwm_mode, clr, duty_wr, ff_wr, ff_val, wdata,
    output count, duty_rd, carry, ff, irq
  );
endinterface

// file: rtl/counter_unit.sv
// One 8-bit up-counter with double-buffered duty register and output flip-flop
`timescale 1ns/1ps
module counter_unit (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Control side
  counter_if.unit bus
);

  logic [7:0] count_r;
  logic [7:0] duty_buf_r;
  logic [7:0] duty_act_r;
  logic ff_r;
  logic irq_r;
  logic pwm_run;
  logic wrap;
  logic hit;

  // --------------------------------------------------------------------
  // Count
  // --------------------------------------------------------------------
  assign pwm_run = bus.run && bus.pwm_mode;
  assign wrap = bus.inc && bus.run && !bus.clr && (count_r == 8'hFF);
  assign hit = bus.inc && (8'(count_r + 8'h01) == duty_act_r);

  // Full 0..FF range gives a 256-tick period
  always_ff @(posedge i_clk) begin
    if (i_reset || !bus.run || bus.clr) begin
      count_r <= 8'h00;
    end else if (bus.inc) begin
      count_r <= 8'(count_r + 8'h01);
    end
  end

  // --------------------------------------------------------------------
  // Output flip-flop
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ff_r <= 1'b0;
    end else if (bus.ff_wr) begin
      ff_r <= bus.ff_val;
    end else if (pwm_run) begin
      ff_r <= ff_r ^ (hit ^ wrap);
    end
  end

  // --------------------------------------------------------------------
  // Duty buffer and interrupt
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      duty_buf_r <= timer_pkg::DUTY_RST;
    end else if (bus.duty_wr) begin
      duty_buf_r <= bus.wdata;
    end
  end

  // A write in the transfer cycle leaves the old buffer in force
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      duty_act_r <= timer_pkg::DUTY_RST;
    end else if (bus.duty_wr && !pwm_run) begin
      duty_act_r <= bus.wdata;
    end else if (pwm_run && wrap) begin
      duty_act_r <= duty_buf_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= pwm_run && wrap;
    end
  end

  assign bus.count = count_r;
  assign bus.duty_rd = duty_act_r;
  assign bus.carry = wrap;
  assign bus.ff = ff_r;
  assign bus.irq = irq_r;

endmodule

// file: rtl/cascadable_timer_pwm.sv
// Two cascadable 8-bit timer/PWM counters behind an AXI4-Lite slave
// Operation
// - PWM mode counts source ticks, flip-flop toggles when count meets duty.
// - PWM overflow toggles flip-flop again and restarts count from zero.
// - PWM overflow raises the counter interrupt pulse.
// - Flip-flop loads its initial value from control bit 7; reset clears it.
// - PWM pin always shows the inverse of the flip-flop.
// - Running PWM buffers duty writes, loading them at the interrupt.
// - Stopped counter takes a duty write into force immediately.
// - Duty read returns the value in force, not the pending one.
// - Stopping the counter holds the pin at its current level.
// - Clearing bit 7 while stopped drives the PWM pin high.
// - 16-bit timer cascades both counters; match interrupts and clears.
// - 16-bit event mode counts external falling edges, match interrupts and clears.
// - Timer and event compare registers are unbuffered and act at once.
`timescale 1ns/1ps
module cascadable_timer_pwm (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // AXI4-Lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Pins
  input wire logic i_low_freq_clock,
  input wire logic i_ext_count,
  output logic [1:0] o_pwm_out_pin,
  output logic [1:0] o_counter_irq
);

  counter_if cif[2] ();

  logic [7:0] ctrl_r [2];
  logic [7:0] period_r [2];
  logic cfg_src_r;
  logic [timer_pkg::PRESCALE_W-1:0] pre_r;
  logic [timer_pkg::LOWFREQ_DIV_W-1:0] lf_div_r;
  logic [timer_pkg::SYNC_STAGES-1:0] sync_r [2];
  logic [1:0] lvl_r;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] tick;
  logic [1:0] run;
  logic cascade;
  logic cas_run;
  logic match16;
  logic irq16_r;
  logic [15:0] cnt16;
  logic [15:0] cmp16;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic wr_fire;
  logic wr_hit;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [7:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] rd_val;
  logic rd_hit;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // Index 0 is the low-frequency clock, index 1 the external count
  logic [1:0] pins;
  assign pins = {i_ext_count, i_low_freq_clock};

  for (genvar k = 0; k < 2; k++) begin : g_sync
    logic agree;
    assign agree = sync_r[k][1] == sync_r[k][2];

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        sync_r[k] <= '0;
      end else begin
        sync_r[k] <= {sync_r[k][1:0], pins[k]};
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        lvl_r[k] <= 1'b0;
      end else if (agree) begin
        lvl_r[k] <= sync_r[k][2];
      end
    end

    assign rise[k] = agree && sync_r[k][2] && !lvl_r[k];
    assign fall[k] = agree && !sync_r[k][2] && lvl_r[k];
  end

  // --------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      lf_div_r <= '0;
    end else if (rise[0]) begin
      lf_div_r <= lf_div_r + 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Counter units
  // --------------------------------------------------------------------
  assign cascade = (timer_pkg::mode_t'(ctrl_r[0][2:0]) == timer_pkg::MODE_LOWER16)
                && (timer_pkg::mode_t'(ctrl_r[1][2:0]) == timer_pkg::MODE_TIMER16);
  assign cas_run = cascade && ctrl_r[1][timer_pkg::CTRL_RUN_BIT];
  assign cnt16 = {cif[1].count, cif[0].count};
  assign cmp16 = {period_r[1], period_r[0]};
  // Count 0..cmp-1, so a compare of N interrupts every N ticks
  assign match16 = cas_run && tick[0] && (16'(cnt16 + 16'h0001) == cmp16);
  assign run[0] = cascade ? cas_run : ctrl_r[0][timer_pkg::CTRL_RUN_BIT];
  assign run[1] = ctrl_r[1][timer_pkg::CTRL_RUN_BIT];

  for (genvar g = 0; g < 2; g++) begin : g_unit
    logic [2:0] sel;
    logic wr_ctrl;
    assign sel = ctrl_r[g][timer_pkg::CTRL_SEL_LSB +: 3];
    assign wr_ctrl = wr_fire && wlane_r
                  && (awaddr_r == (g == 0 ? timer_pkg::OFS_CTRL_LO : timer_pkg::OFS_CTRL_HI));

    always_comb begin
      unique case (timer_pkg::src_t'(sel))
        timer_pkg::SRC_DIV11: begin
          tick[g] = cfg_src_r ? (rise[0] && (&lf_div_r)) : (&pre_r[10:0]);
        end
        timer_pkg::SRC_DIV7: tick[g] = &pre_r[6:0];
        timer_pkg::SRC_DIV5: tick[g] = &pre_r[4:0];
        timer_pkg::SRC_DIV3: tick[g] = &pre_r[2:0];
        timer_pkg::SRC_LOWFREQ: tick[g] = rise[0];
        timer_pkg::SRC_DIV1: tick[g] = pre_r[0];
        timer_pkg::SRC_DIV0: tick[g] = 1'b1;
        timer_pkg::SRC_EXT: tick[g] = fall[1];
      endcase
    end

    counter_unit u_unit (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .bus(cif[g])
    );

    assign cif[g].run = run[g];
    assign cif[g].pwm_mode = !cascade
                          && (timer_pkg::mode_t'(ctrl_r[g][2:0]) == timer_pkg::MODE_PWM8);
    assign cif[g].clr = match16;
    assign cif[g].duty_wr = wr_fire && wlane_r
                  && (awaddr_r == (g == 0 ? timer_pkg::OFS_DUTY_LO : timer_pkg::OFS_DUTY_HI));
    // Writes that stop a running counter leave the flip-flop alone
    assign cif[g].ff_wr = wr_ctrl && !run[g];
    assign cif[g].ff_val = wdata_r[timer_pkg::CTRL_FF_BIT];
    assign cif[g].wdata = wdata_r;
    assign o_pwm_out_pin[g] = !cif[g].ff;
  end

  assign cif[0].inc = cascade ? (tick[0] && cas_run) : tick[0];
  assign cif[1].inc = cascade ? cif[0].carry : tick[1];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq16_r <= 1'b0;
    end else begin
      irq16_r <= match16;
    end
  end

  assign o_counter_irq[0] = cif[0].irq;
  assign o_counter_irq[1] = cif[1].irq || irq16_r;

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  assign o_awready = !aw_got_r && !bvalid_r;
  assign o_wready = !w_got_r && !bvalid_r;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;

  always_comb begin
    unique case (awaddr_r)
      timer_pkg::OFS_CTRL_LO, timer_pkg::OFS_CTRL_HI,
      timer_pkg::OFS_PERIOD_LO, timer_pkg::OFS_PERIOD_HI,
      timer_pkg::OFS_DUTY_LO, timer_pkg::OFS_DUTY_HI,
      timer_pkg::OFS_COUNT_LO, timer_pkg::OFS_COUNT_HI,
      timer_pkg::OFS_CONFIG, timer_pkg::OFS_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || wr_fire) begin
      aw_got_r <= 1'b0;
    end else if (i_awvalid && o_awready) begin
      aw_got_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      awaddr_r <= 8'h00;
    end else if (i_awvalid && o_awready) begin
      awaddr_r <= i_awaddr;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || wr_fire) begin
      w_got_r <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      w_got_r <= 1'b1;
    end
  end

  // Only byte lane 0 carries register data
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      wdata_r <= i_wdata[7:0];
      wlane_r <= i_wstrb[0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bvalid_r <= 1'b0;
      bresp_r <= timer_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_r[0] <= timer_pkg::CTRL_RST;
      ctrl_r[1] <= timer_pkg::CTRL_RST;
    end else if (wr_fire && wlane_r && awaddr_r == timer_pkg::OFS_CTRL_LO) begin
      ctrl_r[0] <= wdata_r;
    end else if (wr_fire && wlane_r && awaddr_r == timer_pkg::OFS_CTRL_HI) begin
      ctrl_r[1] <= wdata_r;
    end
  end

  // Unbuffered: a new compare acts on the very next tick
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      period_r[0] <= timer_pkg::PERIOD_RST;
      period_r[1] <= timer_pkg::PERIOD_RST;
    end else if (wr_fire && wlane_r && awaddr_r == timer_pkg::OFS_PERIOD_LO) begin
      period_r[0] <= wdata_r;
    end else if (wr_fire && wlane_r && awaddr_r == timer_pkg::OFS_PERIOD_HI) begin
      period_r[1] <= wdata_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg_src_r <= 1'b0;
    end else if (wr_fire && wlane_r && awaddr_r == timer_pkg::OFS_CONFIG) begin
      cfg_src_r <= wdata_r[timer_pkg::CFG_SRC_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------
  assign o_arready = !rvalid_r;

  always_comb begin
    rd_hit = 1'b1;
    unique case (i_araddr)
      timer_pkg::OFS_CTRL_LO: rd_val = ctrl_r[0];
      timer_pkg::OFS_CTRL_HI: rd_val = ctrl_r[1];
      timer_pkg::OFS_PERIOD_LO: rd_val = period_r[0];
      timer_pkg::OFS_PERIOD_HI: rd_val = period_r[1];
      timer_pkg::OFS_DUTY_LO: rd_val = cif[0].duty_rd;
      timer_pkg::OFS_DUTY_HI: rd_val = cif[1].duty_rd;
      timer_pkg::OFS_COUNT_LO: rd_val = cif[0].count;
      timer_pkg::OFS_COUNT_HI: rd_val = cif[1].count;
      timer_pkg::OFS_CONFIG: rd_val = {7'h00, cfg_src_r};
      timer_pkg::OFS_STATUS: rd_val = {6'h00, cif[1].ff, cif[0].ff};
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
      rresp_r <= timer_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = {24'h000000, rdata_r};
  assign o_rresp = rresp_r;

endmodule

// file: testbench/timer_assertions.sv
// Port checker for the cascadable timer, bound to its top module
`timescale 1ns/1ps
module timer_assertions (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  // Pins
  input wire logic [1:0] o_pwm_out_pin,
  input wire logic [1:0] o_counter_irq
);
  // ------------------------------
  // Period tracking and properties
  // ------------------------------
  logic [9:0] gap_r;
  logic armed_r;
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // Saturates so long stops never wrap into a false short period
  always_ff @(posedge i_clk) begin
    if (i_reset || o_counter_irq[0]) gap_r <= 10'h000;
    else if (gap_r != 10'h3FF) gap_r <= gap_r + 10'h001;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) armed_r <= 1'b0;
    else if (o_counter_irq[0]) armed_r <= 1'b1;
  end
  pins_reset_a:
    assert property (disable iff (1'b0) i_reset |=> o_pwm_out_pin == 2'b11)
    else $error("pwm pins not high after reset");
  irq_reset_a:
    assert property (disable iff (1'b0) i_reset |=> o_counter_irq == 2'b00)
    else $error("interrupt active after reset");
  pwm_period_a:
    assert property (o_counter_irq[0] && armed_r |-> gap_r >= 10'h0FF)
    else $error("pwm period shorter than 256 ticks");
  irq_quiet_a:
    assert property (o_counter_irq[0] |=> !o_counter_irq[0] [*8])
    else $error("overflow interrupt not a lone pulse");
  ovf_toggle_a:
    assert property (o_counter_irq[0] |-> o_pwm_out_pin[0] != $past(o_pwm_out_pin[0], 2))
    else $error("pin did not toggle at overflow");
  read_answer_a:
    assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered at once");
  read_hold_a:
    assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped before accept");
  write_answer_a:
    assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  write_hold_a:
    assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before accept");
  rdata_zero_a:
    assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  cover property (o_counter_irq[0]);
  cover property (o_counter_irq[1]);
  cover property (o_bvalid && o_bresp == timer_pkg::RESP_SLVERR);
endmodule

bind cascadable_timer_pwm timer_assertions timer_assertions_i (
  .i_clk(i_clk), .i_reset(i_reset), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
  .i_rready(i_rready), .o_rdata(o_rdata), .o_pwm_out_pin(o_pwm_out_pin),
  .o_counter_irq(o_counter_irq)
);

// file: testbench/ext_count_source.sv
// External count source and free low-frequency oscillator
`timescale 1ns/1ps
module ext_count_source #(
  parameter int HOLD = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Command
  input wire logic i_fire,
  input wire logic [7:0] i_edges,
  output logic o_busy,
  // Pins
  output logic o_ext_count,
  output logic o_low_freq_clock
);
  // -----------------
  // Edge generation
  // -----------------
  logic [7:0] left_r;
  logic [3:0] hold_r;
  logic [2:0] lf_r;
  // Each level held HOLD cycles, well above two machine cycles
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      left_r <= 8'h00;
      hold_r <= 4'h0;
      o_ext_count <= 1'b1;
    end else if (i_fire) begin
      left_r <= i_edges;
      hold_r <= 4'h0;
    end else if (hold_r != 4'(HOLD - 1)) begin
      hold_r <= hold_r + 4'h1;
    end else begin
      hold_r <= 4'h0;
      if (!o_ext_count) o_ext_count <= 1'b1;
      else if (left_r != 8'h00) begin
        o_ext_count <= 1'b0;
        left_r <= left_r - 8'h01;
      end
    end
  end
  // Reset keeps the oscillator from starting unknown
  always_ff @(posedge i_clk) begin
    if (i_reset) lf_r <= 3'h0;
    else lf_r <= lf_r + 3'h1;
  end
  assign o_low_freq_clock = lf_r[2];
  assign o_busy = (left_r != 8'h00) || !o_ext_count;
endmodule

// file: testbench/cascadable_timer_pwm_bench.sv
// Self-checking bench for the cascadable timer
`timescale 1ns/1ps
module cascadable_timer_pwm_bench;
  // -------------------
  // Signals and models
  // -------------------
  logic i_clk, i_reset, i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
  logic i_arvalid, o_arready, o_rvalid, i_rready, lf_clk, ext_cnt, fire, busy, pin;
  logic [7:0] i_awaddr, i_araddr, edges, rdat, d1, d2, ctl, dut;
  logic [31:0] i_wdata, o_rdata;
  logic [15:0] n_cmp;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, o_pwm_out_pin, o_counter_irq, resp;
  int failures, checked, cycles, n, lows, pulses;
  cascadable_timer_pwm cascadable_timer_pwm_i (.i_clk(i_clk), .i_reset(i_reset),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .i_low_freq_clock(lf_clk), .i_ext_count(ext_cnt),
    .o_pwm_out_pin(o_pwm_out_pin), .o_counter_irq(o_counter_irq));
  ext_count_source #(.HOLD(8)) ext_count_source_i (.i_clk(i_clk), .i_reset(i_reset),
    .i_fire(fire), .i_edges(edges), .o_busy(busy), .o_ext_count(ext_cnt),
    .o_low_freq_clock(lf_clk));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Hang guard, well above the expected run of some 4500 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  // -------------------
  // Bus and check tasks
  // -------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  // Handshakes read at the falling edge, where ready is settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, b, ta, tw;
    aw = 1'b0;
    w = 1'b0;
    i_awaddr <= a;
    i_wdata <= {24'h000000, d};
    i_wstrb <= 4'h1;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = !aw && o_awready;
      tw = !w && o_wready;
      b = o_bvalid;
      resp = o_bresp;
      @(posedge i_clk);
      if (ta) i_awvalid <= 1'b0;
      if (tw) i_wvalid <= 1'b0;
      aw = aw | ta;
      w = w | tw;
    end while (!b);
    i_bready <= 1'b0;
    // One idle edge, so a following call never lowers and raises ready in one step
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, v;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = o_arready;
      v = o_rvalid;
      rdat = o_rdata[7:0];
      resp = o_rresp;
      @(posedge i_clk);
      if (ta) i_arvalid <= 1'b0;
    end while (!v);
    i_rready <= 1'b0;
    @(posedge i_clk);
  endtask
  // Clocks between matches: source period times the compare value
  function automatic int interval(input int k, input int c);
    return (k == 0) ? 128 : (k == 1) ? c : (k == 2) ? 8 : 64;
  endfunction
  task automatic wait_irq(input int j);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_counter_irq[j] !== 1'b1 && n < 4000);
    if (n >= 4000) chk("interrupt wait", 32'h1, 32'h0);
  endtask
  task automatic lows_of(input int j);
    wait_irq(j);
    lows = 0;
    for (int i = 1; i <= 256; i++) begin
      @(negedge i_clk);
      lows += int'(o_pwm_out_pin[j] === 1'b0);
    end
    chk("interrupt at period end", 1'b1, o_counter_irq[j]);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // -------------------
  // Main sequence
  // -------------------
  initial begin
    {i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, fire} = 7'h40;
    {i_awaddr, i_araddr, edges, i_wdata, i_wstrb} = 60'h0;
    void'($urandom(19));
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    chk("pins after reset", 2'b11, o_pwm_out_pin);
    @(posedge i_clk);
    rd(timer_pkg::OFS_CTRL_LO);
    chk("control reset", timer_pkg::CTRL_RST, rdat);
    rd(8'h28);
    chk("unmapped read", timer_pkg::RESP_SLVERR, resp);
    wr(8'h28, 8'h5A);
    chk("unmapped write", timer_pkg::RESP_SLVERR, resp);
    // Event counting, compare 5, fifteen falling edges
    wr(timer_pkg::OFS_PERIOD_LO, 8'h05);
    wr(timer_pkg::OFS_PERIOD_HI, 8'h00);
    wr(timer_pkg::OFS_CTRL_LO, 8'h73);
    wr(timer_pkg::OFS_CTRL_HI, 8'h04);
    wr(timer_pkg::OFS_CTRL_HI, 8'h0C);
    edges <= 8'h0F;
    fire <= 1'b1;
    @(posedge i_clk);
    fire <= 1'b0;
    pulses = 0;
    do begin
      @(negedge i_clk);
      pulses += int'(o_counter_irq[1] === 1'b1);
    end while (busy || fire);
    repeat (12) begin
      @(negedge i_clk);
      pulses += int'(o_counter_irq[1] === 1'b1);
    end
    chk("event matches", 3, pulses);
    @(posedge i_clk);
    wr(timer_pkg::OFS_CTRL_HI, 8'h04);
    // Cascaded timer: compare 1 on /128, random compare every clock, then low-frequency sources
    for (int k = 0; k < 4; k++) begin
      if (k == 3) wr(timer_pkg::OFS_CONFIG, 8'h01);
      n_cmp = (k == 1) ? 16'(200 + $urandom % 501) : 16'h0001;
      wr(timer_pkg::OFS_PERIOD_LO, n_cmp[7:0]);
      wr(timer_pkg::OFS_PERIOD_HI, n_cmp[15:8]);
      ctl = (k == 0) ? 8'h13 : (k == 1) ? 8'h63 : (k == 2) ? 8'h43 : 8'h03;
      wr(timer_pkg::OFS_CTRL_LO, ctl);
      wr(timer_pkg::OFS_CTRL_HI, 8'h04);
      wr(timer_pkg::OFS_CTRL_HI, 8'h0C);
      wait_irq(1);
      wait_irq(1);
      chk("timer interval", interval(k, n_cmp), n);
      @(posedge i_clk);
      wr(timer_pkg::OFS_CTRL_HI, 8'h04);
    end
    // Pulse width modulation on each unit in turn
    for (int j = 0; j < 2; j++) begin
      ctl = (j == 0) ? timer_pkg::OFS_CTRL_LO : timer_pkg::OFS_CTRL_HI;
      dut = (j == 0) ? timer_pkg::OFS_DUTY_LO : timer_pkg::OFS_DUTY_HI;
      d1 = 8'(20 + $urandom % 211);
      d2 = 8'(20 + $urandom % 211);
      wr(ctl, 8'h62);
      wr(dut, d1);
      rd(dut);
      chk("duty while stopped", d1, rdat);
      wr(ctl, 8'h6A);
      lows_of(j);
      chk("low time", 256 - d1, lows);
      @(posedge i_clk);
      wr(dut, d2);
      rd(dut);
      chk("duty pending", d1, rdat);
      lows_of(j);
      chk("low time new duty", 256 - d2, lows);
      @(posedge i_clk);
      rd(dut);
      chk("duty loaded", d2, rdat);
      wr(ctl, 8'h62);
      @(negedge i_clk);
      pin = o_pwm_out_pin[j];
      repeat (300) @(negedge i_clk);
      chk("pin held when stopped", pin, o_pwm_out_pin[j]);
      @(posedge i_clk);
      wr(ctl, 8'hE2);
      @(negedge i_clk);
      chk("pin after flop set", 1'b0, o_pwm_out_pin[j]);
      @(posedge i_clk);
      wr(ctl, 8'h62);
      @(negedge i_clk);
      chk("pin after flop clear", 1'b1, o_pwm_out_pin[j]);
      @(posedge i_clk);
    end
    complete_run();
  end
endmodule
